// ---- shared/mbrsp_params.svh ----
// Constants for the serial query parser: rates, codes, limits, timing.
// Included by the parser and the master model by bare name.
`ifndef MBRSP_PARAMS_SVH
`define MBRSP_PARAMS_SVH
`define MBR_CLK_HZ    25000000
`define MBR_BAUD0     300
`define MBR_BAUD1     600
`define MBR_BAUD2     1200
`define MBR_BAUD3     2400
`define MBR_BAUD4     4800
`define MBR_BAUD5     9600
`define MBR_BAUD6     14400
`define MBR_BAUD7     19200
`define MBR_BAUD8     28800
`define MBR_BAUD9     38400
`define MBR_BUF_BYTES 50
`define MBR_MIN_LEN   4
`define MBR_FN_READ   8'h03
`define MBR_FN_WR1    8'h06
`define MBR_FN_WRN    8'h10
`define MBR_EXC_BIT   8'h80
`define MBR_EXC_FUNC  8'h01
`define MBR_EXC_ADDR  8'h02
`define MBR_EXC_VAL   8'h03
`define MBR_LO_MAX    8'h4F
`define MBR_HI_MIN    8'h80
`define MBR_HI_MAX    8'h83
`define MBR_CNT_MAX   8'h4F
`define MBR_STA_MIN   8'h01
`define MBR_STA_MAX   8'hF7
`define MBR_CRC_INIT  16'hFFFF
`define MBR_CRC_POLY  16'hA001
`define MBR_GAP_X2    7
`define MBR_LEN_RW    8'h08
`define MBR_LEN_WRN   8'h09
`define MBR_DI_WR1    6'h04
`define MBR_DI_WRN    6'h07
`endif

// ---- shared/mbrsp_pkg.sv ----
// Types shared by the serial query parser, its master model and testbench.
// Assumes mbrsp_params.svh is on the include path.
`default_nettype none
package mbrsp_pkg;
	typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} mbrsp_par_e;
	typedef enum logic [3:0] {
		S_IDLE, S_CHECK, S_WADDR, S_WRITE, S_HDR, S_RADDR, S_RLAT,
		S_RHI, S_RLO, S_CRCH, S_CRCL, S_DRAIN
	} mbrsp_st_e;
	typedef struct packed {
		logic [7:0] station;
		logic [3:0] baud;
		mbrsp_par_e parity;
	} mbrsp_cfg_s;
	typedef struct packed {
		logic        en;
		logic [7:0]  addr;
		logic [15:0] data;
	} mbrsp_wr_s;
endpackage
`default_nettype wire

// ---- rtl/mbrsp_fifo.sv ----
// Small FIFO with valid/ready on both sides, used for reply bytes.
// Single clock; in_ready falls when full, so the writer must stall.
`timescale 1ns/1ps
`default_nettype none
module mbrsp_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 2
) (
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic         clk_en,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [W-1:0]  mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0]   cnt_q;
	logic          put;
	logic          get;

	function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign in_ready  = cnt_q != (AW+1)'(DEPTH);
	assign out_valid = cnt_q != '0;
	assign out_data  = mem_q[rp_q];
	assign put       = in_valid && in_ready;
	assign get       = out_valid && out_ready;

	always_ff @(posedge clock) begin
		if (clk_en && put) begin
			mem_q[wp_q] <= in_data;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else if (clk_en) begin
			if (put) begin
				wp_q <= nxt(wp_q);
			end
			if (get) begin
				rp_q <= nxt(rp_q);
			end
			cnt_q <= cnt_q + (AW+1)'(put) - (AW+1)'(get);
		end
	end
endmodule
`default_nettype wire

// ---- rtl/mbrsp_top.sv ----
// Serial query parser: receives framed queries, serves register reads
// and writes, transmits replies. Register storage lives outside.
`timescale 1ns/1ps
`default_nettype none
`include "mbrsp_params.svh"
module mbrsp_top import mbrsp_pkg::*; #(
	parameter int CLK_HZ = `MBR_CLK_HZ
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        clk_en,
	input  wire logic        rx_pin,
	input  wire mbrsp_cfg_s  cfg,
	input  wire logic [15:0] reg_rd_data,
	input  wire logic        reg_wr_deny,
	output logic [7:0]       reg_addr,
	output var mbrsp_wr_s    wr,
	output logic             tx_pin,
	output logic             tx_oe
);
	function automatic logic [16:0] bit_div(input logic [3:0] s);
		int b;
		case (s)
			4'h0: b = `MBR_BAUD0;
			4'h1: b = `MBR_BAUD1;
			4'h2: b = `MBR_BAUD2;
			4'h3: b = `MBR_BAUD3;
			4'h4: b = `MBR_BAUD4;
			4'h6: b = `MBR_BAUD6;
			4'h7: b = `MBR_BAUD7;
			4'h8: b = `MBR_BAUD8;
			4'h9: b = `MBR_BAUD9;
			default: b = `MBR_BAUD5;
		endcase
		return 17'(CLK_HZ / b);
	endfunction

	function automatic logic [15:0] crc_byte(input logic [15:0] c,
			input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int k = 0; k < 8; k++) begin
			r = r[0] ? ((r >> 1) ^ `MBR_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	function automatic logic in_space(input logic [7:0] a);
		return a <= `MBR_LO_MAX || (a >= `MBR_HI_MIN && a <= `MBR_HI_MAX);
	endfunction

	function automatic logic blk_ok(input logic [7:0] s, input logic [7:0] n);
		logic [8:0] last;
		last = {1'b0, s} + {1'b0, n} - 9'h001;
		return last <= {1'b0, `MBR_LO_MAX} ||
			(s >= `MBR_HI_MIN && last <= {1'b0, `MBR_HI_MAX});
	endfunction

	// ------------------------------------------------------------------
	// Receive line and character framing
	// ------------------------------------------------------------------
	logic        s1_q, s2_q, s3_q, rx_q;
	logic        rx_busy_q, rx_perr_q;
	logic [3:0]  rx_idx_q;
	logic [16:0] rx_cnt_q;
	logic [7:0]  rx_sh_q;
	logic [16:0] div;
	logic        par_on;
	logic [3:0]  stop_idx;
	logic        rx_tick, rx_stop, rx_err;
	mbrsp_st_e   st_q;

	assign div      = bit_div(cfg.baud);
	assign par_on   = cfg.parity != PAR_NONE;
	assign stop_idx = par_on ? 4'hA : 4'h9;
	assign rx_tick  = rx_busy_q && rx_cnt_q == 17'h0;
	assign rx_stop  = rx_tick && rx_idx_q == stop_idx;
	assign rx_err   = rx_perr_q || !rx_q;

	always_ff @(posedge clock) begin
		if (rst) begin
			{s1_q, s2_q, s3_q, rx_q} <= 4'hF;
		end else if (clk_en) begin
			s1_q <= rx_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				rx_q <= s3_q;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rx_busy_q <= 1'b0;
			rx_perr_q <= 1'b0;
			rx_idx_q  <= 4'h0;
			rx_cnt_q  <= 17'h0;
			rx_sh_q   <= 8'h00;
		end else if (clk_en) begin
			if (!rx_busy_q) begin
				rx_cnt_q  <= div >> 1;
				rx_idx_q  <= 4'h0;
				rx_perr_q <= 1'b0;
				rx_busy_q <= !rx_q;
			end else if (!rx_tick) begin
				rx_cnt_q <= rx_cnt_q - 17'h1;
			end else begin
				rx_cnt_q <= div - 17'h1;
				rx_idx_q <= rx_idx_q + 4'h1;
				if (rx_idx_q == 4'h0) begin
					rx_busy_q <= !rx_q;
				end else if (rx_idx_q <= 4'h8) begin
					rx_sh_q <= {rx_q, rx_sh_q[7:1]};
				end else if (rx_stop) begin
					rx_busy_q <= 1'b0;
				end else begin
					rx_perr_q <= (^rx_sh_q ^ rx_q) != (cfg.parity == PAR_ODD);
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Frame collection, silence detection, CRC check
	// ------------------------------------------------------------------
	logic [7:0]  buf_q [`MBR_BUF_BYTES];
	logic [5:0]  len_q, flen_q;
	logic        bad_q;
	logic [15:0] crc0_q, crc1_q, crc2_q;
	logic [21:0] idle_q, gap_cyc;
	logic [5:0]  gap_bits;
	logic        frame_end, frame_ok;

	assign gap_bits  = 6'((`MBR_GAP_X2 * (par_on ? 11 : 10) + 1) / 2);
	assign gap_cyc   = 22'(gap_bits * div);
	// A spoiled frame with no stored byte must still be closed, or its
	// error mark would sink the next good frame
	assign frame_end = (len_q != 6'h0 || bad_q) && idle_q == gap_cyc;
	assign frame_ok  = !bad_q && len_q >= 6'(`MBR_MIN_LEN) &&
		crc2_q == {buf_q[len_q - 6'h2], buf_q[len_q - 6'h1]} &&
		buf_q[0] == cfg.station && cfg.station >= `MBR_STA_MIN &&
		cfg.station <= `MBR_STA_MAX;

	always_ff @(posedge clock) begin
		if (clk_en && rx_stop && !rx_err && st_q == S_IDLE &&
				len_q != 6'(`MBR_BUF_BYTES)) begin
			buf_q[len_q] <= rx_sh_q;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			len_q  <= 6'h0;
			bad_q  <= 1'b0;
			idle_q <= 22'h0;
			crc0_q <= `MBR_CRC_INIT;
			crc1_q <= `MBR_CRC_INIT;
			crc2_q <= `MBR_CRC_INIT;
		end else if (clk_en) begin
			if (rx_busy_q) begin
				idle_q <= 22'h0;
			end else if (idle_q != gap_cyc) begin
				idle_q <= idle_q + 22'h1;
			end
			if (frame_end) begin
				len_q  <= 6'h0;
				bad_q  <= 1'b0;
				crc0_q <= `MBR_CRC_INIT;
				crc1_q <= `MBR_CRC_INIT;
				crc2_q <= `MBR_CRC_INIT;
			end else if (rx_stop) begin
				// Bytes landing while a reply is in progress spoil the frame
				if (rx_err || st_q != S_IDLE ||
						len_q == 6'(`MBR_BUF_BYTES)) begin
					bad_q <= 1'b1;
				end else begin
					len_q  <= len_q + 6'h1;
					crc0_q <= crc_byte(crc0_q, rx_sh_q);
					crc1_q <= crc0_q;
					crc2_q <= crc1_q;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Query check, register access, reply build
	// ------------------------------------------------------------------
	logic [7:0]  fn, cnt, exc_q, n_q, i_q, len_want, push_data;
	logic [5:0]  di_q;
	logic [2:0]  pos_q;
	logic [15:0] rd_q, txcrc_q;
	logic        is_read, cnt_bad, hdr_last, push_valid, push_ready;
	logic        push_fire;

	assign fn       = buf_q[1];
	assign cnt      = buf_q[5];
	assign is_read  = fn == `MBR_FN_READ;
	assign cnt_bad  = buf_q[4] != 8'h00 || cnt == 8'h00 ||
		cnt > `MBR_CNT_MAX;
	assign len_want = (fn == `MBR_FN_WRN) ?
		`MBR_LEN_WRN + {cnt[6:0], 1'b0} : `MBR_LEN_RW;
	assign hdr_last = pos_q == ((exc_q != 8'h00 || is_read) ? 3'h2 : 3'h5);
	assign push_valid = st_q == S_HDR || st_q == S_RHI || st_q == S_RLO ||
		st_q == S_CRCH || st_q == S_CRCL;
	assign push_fire  = push_valid && push_ready;

	always_comb begin
		push_data = buf_q[pos_q];
		case (st_q)
			S_HDR: begin
				if (pos_q == 3'h1 && exc_q != 8'h00) begin
					push_data = fn | `MBR_EXC_BIT;
				end else if (pos_q == 3'h2 && exc_q != 8'h00) begin
					push_data = exc_q;
				end else if (pos_q == 3'h2 && is_read) begin
					push_data = {n_q[6:0], 1'b0};
				end
			end
			S_RHI: push_data = rd_q[15:8];
			S_RLO: push_data = rd_q[7:0];
			S_CRCH: push_data = txcrc_q[15:8];
			S_CRCL: push_data = txcrc_q[7:0];
			default: push_data = buf_q[pos_q];
		endcase
	end

	logic       tx_busy_q, tx_take, out_valid;
	logic [7:0] out_data;

	always_ff @(posedge clock) begin
		if (rst) begin
			st_q <= S_IDLE;
			exc_q <= 8'h00;
			{n_q, i_q, di_q, pos_q} <= '0;
			rd_q <= 16'h0000;
			txcrc_q <= `MBR_CRC_INIT;
			reg_addr <= 8'h00;
		end else if (clk_en) begin
			case (st_q)
				S_IDLE: begin
					flen_q <= len_q;
					if (frame_end && frame_ok) begin
						st_q <= S_CHECK;
					end
				end
				S_CHECK: begin
					{exc_q, i_q, pos_q} <= '0;
					txcrc_q <= `MBR_CRC_INIT;
					if (!is_read && fn != `MBR_FN_WR1 && fn != `MBR_FN_WRN) begin
						exc_q <= `MBR_EXC_FUNC;
						st_q <= S_HDR;
					end else if ({2'b00, flen_q} != len_want) begin
						st_q <= S_IDLE;
					end else if (buf_q[2] != 8'h00 || !in_space(buf_q[3])) begin
						exc_q <= `MBR_EXC_ADDR;
						st_q <= S_HDR;
					end else if (fn == `MBR_FN_WR1) begin
						n_q <= 8'h01;
						di_q <= `MBR_DI_WR1;
						st_q <= S_WADDR;
					end else if (cnt_bad || (fn == `MBR_FN_WRN &&
							buf_q[6] != {cnt[6:0], 1'b0})) begin
						exc_q <= `MBR_EXC_VAL;
						st_q <= S_HDR;
					end else if (!blk_ok(buf_q[3], cnt)) begin
						exc_q <= `MBR_EXC_ADDR;
						st_q <= S_HDR;
					end else begin
						n_q <= cnt;
						di_q <= `MBR_DI_WRN;
						st_q <= is_read ? S_HDR : S_WADDR;
					end
				end
				S_WADDR: begin
					reg_addr <= buf_q[3] + i_q;
					st_q <= S_WRITE;
				end
				S_WRITE: begin
					if (reg_wr_deny) begin
						exc_q <= `MBR_EXC_VAL;
						st_q <= S_HDR;
					end else begin
						di_q <= di_q + 6'h2;
						i_q <= i_q + 8'h01;
						st_q <= (i_q + 8'h01 == n_q) ? S_HDR : S_WADDR;
					end
				end
				S_HDR: begin
					if (push_fire) begin
						txcrc_q <= crc_byte(txcrc_q, push_data);
						pos_q <= pos_q + 3'h1;
						if (hdr_last) begin
							st_q <= (is_read && exc_q == 8'h00) ? S_RADDR : S_CRCH;
						end
					end
				end
				S_RADDR: begin
					reg_addr <= buf_q[3] + i_q;
					st_q <= S_RLAT;
				end
				S_RLAT: begin
					rd_q <= reg_rd_data;
					st_q <= S_RHI;
				end
				S_RHI, S_RLO: begin
					if (push_fire) begin
						txcrc_q <= crc_byte(txcrc_q, push_data);
						if (st_q == S_RHI) begin
							st_q <= S_RLO;
						end else begin
							i_q <= i_q + 8'h01;
							st_q <= (i_q + 8'h01 == n_q) ? S_CRCH : S_RADDR;
						end
					end
				end
				S_CRCH: st_q <= push_fire ? S_CRCL : S_CRCH;
				S_CRCL: st_q <= push_fire ? S_DRAIN : S_CRCL;
				default: begin
					if (!out_valid && !tx_busy_q) begin
						st_q <= S_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			wr <= '0;
		end else if (clk_en) begin
			wr.en <= st_q == S_WRITE && !reg_wr_deny;
			wr.addr <= reg_addr;
			wr.data <= {buf_q[di_q], buf_q[di_q + 6'h1]};
		end
	end

	// ------------------------------------------------------------------
	// Reply buffer and transmitter
	// ------------------------------------------------------------------
	logic [16:0] tx_cnt_q;
	logic [3:0]  tx_idx_q;
	logic [9:0]  tx_sh_q;

	// Two entries let the builder run ahead across a register fetch
	mbrsp_fifo #(.W(8), .DEPTH(2)) u_fifo (
		.clock     (clock),
		.rst       (rst),
		.clk_en    (clk_en),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.in_data   (push_data),
		.out_valid (out_valid),
		.out_ready (!tx_busy_q),
		.out_data  (out_data)
	);

	assign tx_take = out_valid && !tx_busy_q;

	always_ff @(posedge clock) begin
		if (rst) begin
			tx_busy_q <= 1'b0;
			tx_cnt_q <= 17'h0;
			tx_idx_q <= 4'h0;
			tx_sh_q <= 10'h3FF;
			tx_pin <= 1'b1;
			tx_oe <= 1'b0;
		end else if (clk_en) begin
			if (tx_take) begin
				tx_sh_q <= {1'b1, par_on ?
					(^out_data ^ (cfg.parity == PAR_ODD)) : 1'b1, out_data};
				tx_pin <= 1'b0;
				tx_oe <= 1'b1;
				tx_busy_q <= 1'b1;
				tx_idx_q <= 4'h0;
				tx_cnt_q <= div - 17'h1;
			end else if (tx_busy_q && tx_cnt_q != 17'h0) begin
				tx_cnt_q <= tx_cnt_q - 17'h1;
			end else if (tx_busy_q && tx_idx_q == stop_idx) begin
				tx_busy_q <= 1'b0;
			end else if (tx_busy_q) begin
				tx_pin <= tx_sh_q[0];
				tx_sh_q <= {1'b1, tx_sh_q[9:1]};
				tx_idx_q <= tx_idx_q + 4'h1;
				tx_cnt_q <= div - 17'h1;
			end else if (st_q == S_IDLE) begin
				tx_oe <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence take_s;
		clk_en && tx_take;
	endsequence

	line_idle_a: assert property (!tx_oe |-> tx_pin)
		else $error("line not idle high while released");
	start_bit_a: assert property (take_s |=> !tx_pin && tx_oe)
		else $error("no start bit after byte take");
	bit_time_a: assert property (tx_oe && $changed(tx_pin) |->
		$past(tx_cnt_q) == 17'h0 || $past(tx_take))
		else $error("line changed inside a bit time");
	buf_cap_a: assert property (len_q <= 6'(`MBR_BUF_BYTES))
		else $error("receive count beyond buffer");
	drop_bad_a: assert property (frame_end && bad_q && st_q == S_IDLE
		|=> st_q == S_IDLE)
		else $error("bad frame was acted on");
	exc_fn_a: assert property (st_q == S_HDR && pos_q == 3'h1 &&
		exc_q != 8'h00 |-> push_data == (fn | `MBR_EXC_BIT))
		else $error("exception function byte wrong");
	exc_len_a: assert property (st_q == S_HDR && exc_q != 8'h00 &&
		push_fire && pos_q == 3'h2 |=> st_q == S_CRCH)
		else $error("exception reply not five bytes");
	exc_code_a: assert property (exc_q != 8'h00 |->
		exc_q inside {`MBR_EXC_FUNC, `MBR_EXC_ADDR, `MBR_EXC_VAL})
		else $error("exception code out of set");
	wr_gate_a: assert property (wr.en |-> !$past(reg_wr_deny) &&
		in_space(wr.addr))
		else $error("write issued to denied or absent register");
	own_sta_a: assert property (st_q == S_HDR && pos_q == 3'h0 |->
		push_data == cfg.station)
		else $error("reply not from own station");
endmodule
`default_nettype wire

// ---- verif/mbrsp_master_model.sv ----
// Serial master model: sends framed queries to the parser, collects
// reply characters. Assumes one bit lasts DIV clocks on both wires.
`timescale 1ns/1ps
`default_nettype none
`include "mbrsp_params.svh"
module mbrsp_master_model import mbrsp_pkg::*; #(
	parameter int DIV = 10
) (
	input  wire logic       clock,
	input  wire mbrsp_par_e parity,
	input  wire logic       tx_line,
	input  wire logic       tx_oe,
	output logic            rx_line
);
	logic [7:0] reply_q[$];
	logic       rx_fault;
	logic [7:0] rbyte;
	initial begin
		rx_line = 1'b1;
		rx_fault = 1'b0;
	end
	// ------------------------------------------------------------
	// Check value, high byte sent first
	// ------------------------------------------------------------
	function automatic logic [15:0] crc16(input logic [7:0] f[$]);
		logic [15:0] c;
		c = `MBR_CRC_INIT;
		foreach (f[i]) begin
			c = c ^ {8'h00, f[i]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? ((c >> 1) ^ `MBR_CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction
	task automatic drive_bit(input logic v);
		rx_line <= v;
		repeat (DIV) @(posedge clock);
	endtask
	task automatic send_byte(input logic [7:0] b, input logic bad_par);
		drive_bit(1'b0);
		for (int i = 0; i < 8; i++)
			drive_bit(b[i]);
		if (parity != PAR_NONE)
			drive_bit((^b) ^ (parity == PAR_ODD) ^ bad_par);
		drive_bit(1'b1);
	endtask
	// Line stays at the stop level between frames, so silence ends it
	task automatic send_frame(input logic [7:0] f[$], input logic bad_crc,
		input int bad_par_at);
		logic [15:0] c;
		c = crc16(f) ^ {15'h0000, bad_crc};
		f.push_back(c[15:8]);
		f.push_back(c[7:0]);
		@(posedge clock);
		foreach (f[i])
			send_byte(f[i], i == bad_par_at);
	endtask
	// ------------------------------------------------------------
	// Reply receiver, samples mid-bit
	// ------------------------------------------------------------
	always begin
		@(posedge clock);
		if (tx_oe === 1'b1 && tx_line === 1'b0) begin
			repeat (DIV / 2) @(posedge clock);
			for (int i = 0; i < 8; i++) begin
				repeat (DIV) @(posedge clock);
				rbyte[i] = tx_line;
			end
			if (parity != PAR_NONE) begin
				repeat (DIV) @(posedge clock);
				if (tx_line !== ((^rbyte) ^ (parity == PAR_ODD)))
					rx_fault = 1'b1;
			end
			repeat (DIV) @(posedge clock);
			if (tx_line !== 1'b1)
				rx_fault = 1'b1;
			reply_q.push_back(rbyte);
		end
	end
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// Testbench for the serial query parser: drives queries through the
// master model, serves registers from an address-derived pattern.
`timescale 1ns/1ps
`default_nettype none
module tb_top import mbrsp_pkg::*;;
	// Bit time of 10 clocks: 384000 / 38400
	localparam int HZ  = 384000;
	localparam int DIV = 10;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        rx_line;
	mbrsp_cfg_s  cfg = '{station: 8'h11, baud: 4'h9, parity: PAR_NONE};
	logic [15:0] reg_rd_data;
	logic        reg_wr_deny;
	logic [7:0]  reg_addr;
	mbrsp_wr_s   wr;
	logic        tx_pin;
	logic        tx_oe;
	logic [23:0] wr_log[$];
	int          failures = 0;
	int          check_count = 0;
	always #20 clock = ~clock;
	assign reg_rd_data = {reg_addr ^ 8'hA5, reg_addr};
	// Address 130 stands for a protected register
	assign reg_wr_deny = (reg_addr == 8'h82);
	always @(posedge clock)
		if (wr.en === 1'b1)
			wr_log.push_back({wr.addr, wr.data});
	mbrsp_top #(.CLK_HZ(HZ)) DUT (
		.clock(clock), .rst(rst), .clk_en(1'b1), .rx_pin(rx_line),
		.cfg(cfg), .reg_rd_data(reg_rd_data), .reg_wr_deny(reg_wr_deny),
		.reg_addr(reg_addr), .wr(wr), .tx_pin(tx_pin), .tx_oe(tx_oe)
	);
	mbrsp_master_model #(.DIV(DIV)) M (
		.clock(clock), .parity(cfg.parity), .tx_line(tx_pin),
		.tx_oe(tx_oe), .rx_line(rx_line)
	);
	// ------------------------------------------------------------
	// Shared helpers
	// ------------------------------------------------------------
	task automatic tally_and_finish();
		if (failures == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic compare_ok(input logic ok, input string msg);
		check_count++;
		if (ok !== 1'b1) begin
			failures++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	// Reply must wait for the full silence, then come promptly
	task automatic await_reply(input logic expect_tx);
		int n;
		n = 0;
		while (tx_oe !== 1'b1 && n < 600) begin
			@(posedge clock);
			n++;
		end
		if (expect_tx) begin
			compare_ok(n >= 330 && n <= 400, "reply start time");
			n = 0;
			while (tx_oe === 1'b1 && n < 20000) begin
				@(posedge clock);
				n++;
			end
			repeat (20) @(posedge clock);
		end else
			compare_ok(n == 600 && M.reply_q.size() == 0,
				"reply seen");
	endtask
	task automatic check_reply(input logic [7:0] e[$]);
		logic [15:0] c;
		c = M.crc16(e);
		e.push_back(c[15:8]);
		e.push_back(c[7:0]);
		compare_ok(M.reply_q.size() == e.size(), "reply length");
		foreach (e[i])
			if (i < M.reply_q.size())
				compare_ok(M.reply_q[i] === e[i], "reply byte");
		compare_ok(M.rx_fault === 1'b0, "reply framing");
		M.reply_q.delete();
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_read(input logic [7:0] sta, input mbrsp_par_e par,
		input logic [7:0] start, input logic [7:0] cnt);
		logic [7:0] f[$];
		logic [7:0] e[$];
		logic [7:0] a;
		cfg.station <= sta;
		cfg.parity <= par;
		repeat (4) @(posedge clock);
		f = '{sta, 8'h03, 8'h00, start, 8'h00, cnt};
		M.send_frame(f, 1'b0, -1);
		await_reply(1'b1);
		e = '{sta, 8'h03, {cnt[6:0], 1'b0}};
		a = start;
		repeat (cnt) begin
			e.push_back(a ^ 8'hA5);
			e.push_back(a);
			a = a + 8'h01;
		end
		check_reply(e);
		compare_ok(wr_log.size() == 0, "write during read");
	endtask
	task automatic t_write_one();
		logic [7:0] f[$];
		f = '{8'h11, 8'h06, 8'h00, 8'h05, 8'h12, 8'h34};
		M.send_frame(f, 1'b0, -1);
		await_reply(1'b1);
		compare_ok(wr_log.size() == 1, "write count");
		compare_ok(wr_log[0] === 24'h051234, "write word");
		check_reply(f);
		wr_log.delete();
	endtask
	task automatic t_write_multi();
		logic [7:0] f[$];
		f = '{8'h11, 8'h10, 8'h00, 8'h0A, 8'h00, 8'h02, 8'h04,
			8'hAA, 8'hBB, 8'hCC, 8'hDD};
		M.send_frame(f, 1'b0, -1);
		await_reply(1'b1);
		compare_ok(wr_log.size() == 2, "multi write count");
		compare_ok(wr_log[0] === 24'h0AAABB, "first word");
		compare_ok(wr_log[1] === 24'h0BCCDD, "second word");
		check_reply(f[0:5]);
		wr_log.delete();
	endtask
	task automatic t_exceptions();
		logic [47:0] q[6];
		logic [7:0]  code[6];
		logic [7:0]  f[$];
		q = '{48'h1104_0000_0001, 48'h1103_0050_0001, 48'h1103_0000_0000,
			48'h1103_0000_0050, 48'h1103_004F_0002, 48'h1106_0082_0001};
		code = '{8'h01, 8'h02, 8'h03, 8'h03, 8'h02, 8'h03};
		for (int i = 0; i < 6; i++) begin
			f.delete();
			for (int j = 0; j < 6; j++)
				f.push_back(q[i][47 - 8 * j -: 8]);
			M.send_frame(f, 1'b0, -1);
			await_reply(1'b1);
			check_reply('{8'h11, f[1] | 8'h80, code[i]});
			compare_ok(wr_log.size() == 0, "denied write done");
		end
	endtask
	task automatic t_discard();
		logic [7:0] f[$];
		f = '{8'h11, 8'h03, 8'h00, 8'h01, 8'h00, 8'h01};
		M.send_frame(f, 1'b1, -1);
		await_reply(1'b0);
		f[0] = 8'h12;
		M.send_frame(f, 1'b0, -1);
		await_reply(1'b0);
		f[0] = 8'h11;
		// One surplus byte: good check value, wrong length for a read
		f.push_back(8'h00);
		M.send_frame(f, 1'b0, -1);
		await_reply(1'b0);
		void'(f.pop_back());
		cfg.parity <= PAR_EVEN;
		repeat (4) @(posedge clock);
		M.send_frame(f, 1'b0, 3);
		await_reply(1'b0);
		cfg.parity <= PAR_NONE;
		f = '{8'h11, 8'h10, 8'h00, 8'h00, 8'h00, 8'h15, 8'h2A};
		repeat (42) f.push_back(8'h5A);
		M.send_frame(f, 1'b0, -1);
		await_reply(1'b0);
		compare_ok(wr_log.size() == 0, "overlong frame written");
	endtask
	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		repeat (6) @(posedge clock);
		t_read(8'h11, PAR_NONE, 8'h05, 8'h02);
		t_write_one();
		t_write_multi();
		t_exceptions();
		t_discard();
		t_read(8'hF7, PAR_ODD, 8'h80, 8'h04);
		t_read(8'h01, PAR_EVEN, 8'h4F, 8'h01);
		tally_and_finish();
	end
	initial begin
		repeat (90000) @(posedge clock);
		failures++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
